// ---- cmp_control.sv ----
// Comparator control, mismatch event flag, wake and timer gate logic behind an AXI4-Lite slave
// Behaviour
// - Results always readable; driven to pins only in mode 110.
// - Reported result is raw comparison XOR its invert bit (bits 5, 4).
// - Read-only result b at bit 7, a at bit 6, reset zero.
// - Input switch acts only in modes 001 and 010; both pins stay analog.
// - Switch bit 3 set selects plus pin as inverting input; mode 001 only a.
// - Mode field bits 2-0 selects the six active configurations.
// - Modes 000 and 111 are off; 111 returns pins to digital use.
// - Reference latch captures results on each config read or write, held until the next one.
// - Second latch samples each first quarter phase; difference is a mismatch.
// - Mismatch holds flag set until config read or output returns.
// - Any config write with strobe bit 0 set also clears the mismatch.
// - Flag cleared only by software writing zero; writing one sets it.
// - Interrupt needs all three enables; flag sets regardless.
// - Clearing flag has no effect while mismatch persists.
// - Change coinciding with a config read may fail to set the flag.
// - Comparators run in sleep; change wakes if cmp and peripheral enables set.
// - Reset returns config to mode 000 and link register to reset value.
// - Gate select clear makes result b gate the timer.
// - Pins in analog use read as zero.
// - With sync set, result b latched on timer clock falling edge.
// - Gate select set picks external gate pin; resets to one.
module cmp_control (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cmp_a_raw,
	input wire logic cmp_b_raw,
	input wire logic timer_clk_prescaled,
	input wire logic ext_gate_pin,
	input wire logic sleeping,
	output logic cmp_a_pin_out,
	output logic cmp_b_pin_out,
	output logic pin_out_enable,
	output logic [3:0] input_analog,
	output logic input_switch_sel,
	output logic cmp_a_enable,
	output logic cmp_b_enable,
	output logic timer_gate,
	output logic irq_request,
	output logic wake_request
);
	typedef struct packed {
		logic [5:0] config_bits;
		logic [1:0] link;
		logic [2:0] enables;
		logic flag;
		logic [1:0] ref_latch;
		logic [1:0] q1_latch;
		logic [1:0] phase;
		logic tclk_prev;
		logic b_synced_timer;
		logic awready;
		logic wready;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic have_aw;
		logic have_w;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic a_pin;
		logic b_pin;
		logic pin_oe;
		logic [3:0] analog;
		logic sw_sel;
		logic a_en;
		logic b_en;
		logic gate;
		logic irq;
		logic wake;
	} state_t;
	state_t state_reg;
	state_t state_next;
	logic [1:0] raw_sync;
	logic [1:0] ext_sync;
	cmp_sync2 #(.width(2)) u_cmp_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({cmp_b_raw, cmp_a_raw}),
		.sync_out(raw_sync)
	);
	cmp_sync2 #(.width(2)) u_ext_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({timer_clk_prescaled, ext_gate_pin}),
		.sync_out(ext_sync)
	);
	logic [2:0] mode;
	logic cmp_off;
	logic [1:0] result;
	logic [1:0] invert;
	logic q1_tick;
	logic mismatch;
	logic cfg_read;
	logic cfg_write;
	logic wr_fire;
	logic [7:0] cfg_view;
	logic b_for_gate;
	always_comb begin
		state_next = state_reg;
		mode = state_reg.config_bits[2:0];
		invert = {state_reg.config_bits[cmp_pkg::cfg_b_invert], state_reg.config_bits[cmp_pkg::cfg_a_invert]};
		cmp_off = (mode == cmp_pkg::mode_off_analog) || (mode == cmp_pkg::mode_off_digital);
		// Disabled comparators report zero so no spurious mismatch appears
		result = cmp_off ? 2'h0 : (raw_sync ^ invert);
		if (mode == cmp_pkg::mode_one_indep) begin
			result[1] = 1'b0;
		end
		cfg_view = {state_reg.q1_latch, state_reg.config_bits};
		q1_tick = (state_reg.phase == 2'h0);
		mismatch = (state_reg.q1_latch != state_reg.ref_latch);
		cfg_read = 1'b0;
		cfg_write = 1'b0;
		state_next.phase = (state_reg.phase == cmp_pkg::quarter_last) ? 2'h0 : state_reg.phase + 2'h1;
		if (q1_tick) begin
			state_next.q1_latch = result;
		end
		// Read channel, one beat at a time
		state_next.arready = 1'b0;
		if (state_reg.rvalid && s_axi_rready) begin
			state_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !state_reg.rvalid && !state_reg.arready) begin
			state_next.arready = 1'b1;
			state_next.rvalid = 1'b1;
			state_next.rresp = cmp_pkg::resp_okay;
			state_next.rdata = 32'h0;
			case (s_axi_araddr)
				cmp_pkg::addr_config: begin
					state_next.rdata = {24'h0, cfg_view};
					cfg_read = 1'b1;
				end
				cmp_pkg::addr_timer_link: state_next.rdata = {30'h0, state_reg.link};
				cmp_pkg::addr_flags: state_next.rdata = {30'h0, mismatch, state_reg.flag};
				cmp_pkg::addr_enables: state_next.rdata = {29'h0, state_reg.enables};
				cmp_pkg::addr_raw: state_next.rdata = {30'h0, raw_sync};
				default: state_next.rresp = cmp_pkg::resp_slverr;
			endcase
		end
		// Write channel: address and data in either order
		state_next.awready = 1'b0;
		state_next.wready = 1'b0;
		if (s_axi_awvalid && !state_reg.have_aw && !state_reg.awready && !state_reg.bvalid) begin
			state_next.awready = 1'b1;
			state_next.have_aw = 1'b1;
			state_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !state_reg.have_w && !state_reg.wready && !state_reg.bvalid) begin
			state_next.wready = 1'b1;
			state_next.have_w = 1'b1;
			state_next.wdata = s_axi_wdata;
			state_next.wstrb = s_axi_wstrb;
		end
		if (state_reg.bvalid && s_axi_bready) begin
			state_next.bvalid = 1'b0;
		end
		wr_fire = state_reg.have_aw && state_reg.have_w && !state_reg.bvalid;
		if (wr_fire) begin
			state_next.have_aw = 1'b0;
			state_next.have_w = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = cmp_pkg::resp_okay;
			if (state_reg.wstrb[0]) begin
				case (state_reg.awaddr)
					cmp_pkg::addr_config: begin
						state_next.config_bits = state_reg.wdata[5:0];
						cfg_write = 1'b1;
					end
					cmp_pkg::addr_timer_link: state_next.link = state_reg.wdata[1:0];
					cmp_pkg::addr_flags: state_next.flag = state_reg.wdata[0];
					cmp_pkg::addr_enables: state_next.enables = state_reg.wdata[2:0];
					cmp_pkg::addr_raw: state_next.bresp = cmp_pkg::resp_okay;
					default: state_next.bresp = cmp_pkg::resp_slverr;
				endcase
			end else if (!(state_reg.awaddr inside {cmp_pkg::addr_config, cmp_pkg::addr_timer_link,
				cmp_pkg::addr_flags, cmp_pkg::addr_enables, cmp_pkg::addr_raw})) begin
				state_next.bresp = cmp_pkg::resp_slverr;
			end
		end
		// A write starts with a read, so it recaptures the reference too
		if (cfg_read || cfg_write) begin
			state_next.ref_latch = state_reg.q1_latch;
		end
		// Mismatch wins over a software clear; a read in the same cycle can hide it
		if (mismatch && !cfg_read && !cfg_write) begin
			state_next.flag = 1'b1;
		end
		// Outputs
		state_next.a_pin = result[0];
		state_next.b_pin = result[1];
		state_next.pin_oe = (mode == cmp_pkg::mode_pin_out);
		state_next.analog = (mode == cmp_pkg::mode_off_digital) ? 4'h0 : 4'hf;
		state_next.sw_sel = state_reg.config_bits[cmp_pkg::cfg_switch]
			&& ((mode == cmp_pkg::mode_three_in) || (mode == cmp_pkg::mode_four_in));
		state_next.a_en = !cmp_off;
		state_next.b_en = !cmp_off && (mode != cmp_pkg::mode_one_indep);
		state_next.tclk_prev = ext_sync[1];
		if (state_reg.tclk_prev && !ext_sync[1]) begin
			state_next.b_synced_timer = result[1];
		end
		b_for_gate = state_reg.link[cmp_pkg::link_sync] ? state_reg.b_synced_timer : result[1];
		state_next.gate = state_reg.link[cmp_pkg::link_gate_sel] ? ext_sync[0] : b_for_gate;
		state_next.irq = state_reg.flag && state_reg.enables[cmp_pkg::en_cmp]
			&& state_reg.enables[cmp_pkg::en_periph] && state_reg.enables[cmp_pkg::en_global];
		state_next.wake = sleeping && state_reg.flag && state_reg.enables[cmp_pkg::en_cmp]
			&& state_reg.enables[cmp_pkg::en_periph];
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= '0;
			state_reg.config_bits <= cmp_pkg::config_reset[5:0];
			state_reg.link <= cmp_pkg::link_reset;
			state_reg.analog <= 4'hf;
			state_reg.gate <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end
	assign s_axi_awready = state_reg.awready;
	assign s_axi_wready = state_reg.wready;
	assign s_axi_bresp = state_reg.bresp;
	assign s_axi_bvalid = state_reg.bvalid;
	assign s_axi_arready = state_reg.arready;
	assign s_axi_rdata = state_reg.rdata;
	assign s_axi_rresp = state_reg.rresp;
	assign s_axi_rvalid = state_reg.rvalid;
	assign cmp_a_pin_out = state_reg.a_pin;
	assign cmp_b_pin_out = state_reg.b_pin;
	assign pin_out_enable = state_reg.pin_oe;
	assign input_analog = state_reg.analog;
	assign input_switch_sel = state_reg.sw_sel;
	assign cmp_a_enable = state_reg.a_en;
	assign cmp_b_enable = state_reg.b_en;
	assign timer_gate = state_reg.gate;
	assign irq_request = state_reg.irq;
	assign wake_request = state_reg.wake;
endmodule

// ---- cmp_pkg.sv ----
// Package with register map, field positions, reset values and modes of the comparator control block
package cmp_pkg;
	localparam logic [7:0] addr_config = 8'h00;
	localparam logic [7:0] addr_timer_link = 8'h04;
	localparam logic [7:0] addr_flags = 8'h08;
	localparam logic [7:0] addr_enables = 8'h0c;
	localparam logic [7:0] addr_raw = 8'h10;
	localparam int cfg_b_result = 7;
	localparam int cfg_a_result = 6;
	localparam int cfg_b_invert = 5;
	localparam int cfg_a_invert = 4;
	localparam int cfg_switch = 3;
	localparam int link_gate_sel = 1;
	localparam int link_sync = 0;
	localparam int en_global = 2;
	localparam int en_periph = 1;
	localparam int en_cmp = 0;
	localparam logic [7:0] config_reset = 8'h00;
	localparam logic [1:0] link_reset = 2'h2;
	localparam logic [2:0] mode_off_analog = 3'h0;
	localparam logic [2:0] mode_three_in = 3'h1;
	localparam logic [2:0] mode_four_in = 3'h2;
	localparam logic [2:0] mode_common_ref = 3'h3;
	localparam logic [2:0] mode_two_indep = 3'h4;
	localparam logic [2:0] mode_one_indep = 3'h5;
	localparam logic [2:0] mode_pin_out = 3'h6;
	localparam logic [2:0] mode_off_digital = 3'h7;
	localparam int quarter_count = 4;
	localparam logic [1:0] quarter_last = 2'(quarter_count - 1);
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// ---- cmp_sync2.sv ----
// Two-stage synchroniser for a vector of asynchronous levels
module cmp_sync2 #(
	parameter int width = 2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [width-1:0] async_in,
	output logic [width-1:0] sync_out
);
	typedef struct packed {
		logic [width-1:0] stage1;
		logic [width-1:0] stage2;
	} state_t;
	state_t state_reg;
	state_t state_next;
	always_comb begin
		state_next.stage1 = async_in;
		state_next.stage2 = state_reg.stage1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
	assign sync_out = state_reg.stage2;
endmodule

// ---- cmp_control_checker.sv ----
// Port checker for the comparator control block
module cmp_control_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic sleeping,
	input wire logic cmp_a_pin_out,
	input wire logic pin_out_enable,
	input wire logic [3:0] input_analog,
	input wire logic input_switch_sel,
	input wire logic cmp_a_enable,
	input wire logic irq_request,
	input wire logic wake_request
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_pin_mode: assert property (pin_out_enable |-> input_analog == 4'hf && cmp_a_enable)
		else $error("pin drive outside pin output mode");
	a_switch_mode: assert property (input_switch_sel |-> cmp_a_enable && !pin_out_enable)
		else $error("input switch active in wrong mode");
	a_off_zero: assert property (!cmp_a_enable && $past(!cmp_a_enable) |-> !cmp_a_pin_out)
		else $error("result shown while off");
	a_wake_irq: assert property (irq_request && $past(sleeping) |-> wake_request)
		else $error("no wake while request pending");
	a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
		else $error("read not answered");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read data dropped");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_reset_state: assert property (disable iff (1'b0) !aresetn |=> input_analog == 4'hf && !irq_request)
		else $error("wrong state after reset");
	c_irq: cover property (irq_request);
	c_wake: cover property (wake_request);
	c_pins: cover property (pin_out_enable);
endmodule
bind cmp_control cmp_control_checker cmp_control_checker_inst (
	.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid,
	.s_axi_bready, .sleeping, .cmp_a_pin_out, .pin_out_enable, .input_analog, .input_switch_sel,
	.cmp_a_enable, .irq_request, .wake_request
);

// ---- test_dual_comparator_control.sv ----
// Self-checking testbench for the comparator control block
module test_dual_comparator_control;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] cfg = cmp_pkg::addr_config;
	localparam logic [7:0] flg = cmp_pkg::addr_flags;
	localparam logic [7:0] lnk = cmp_pkg::addr_timer_link;
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cmp_a_raw = 1'b0, cmp_b_raw = 1'b0;
	logic timer_clk_prescaled = 1'b0, ext_gate_pin = 1'b0, sleeping = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cmp_a_pin_out, cmp_b_pin_out;
	logic pin_out_enable, input_switch_sel, cmp_a_enable, cmp_b_enable, timer_gate, irq_request, wake_request;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [3:0] input_analog;
	int mismatches = 0, check_count = 0;
	logic [1:0] last_bresp = 2'h0;
	cmp_control cmp_control_inst (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.cmp_a_raw, .cmp_b_raw, .timer_clk_prescaled, .ext_gate_pin, .sleeping, .cmp_a_pin_out,
		.cmp_b_pin_out, .pin_out_enable, .input_analog, .input_switch_sel, .cmp_a_enable, .cmp_b_enable,
		.timer_gate, .irq_request, .wake_request
	);
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (n < 40) begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bready && s_axi_bvalid) begin
				last_bresp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				n = 99;
			end else if (!s_axi_awvalid && !s_axi_wvalid) s_axi_bready <= 1'b1;
		end
		if (n != 99) mismatches++;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (n < 40) begin
			@(posedge aclk);
			n++;
			if (s_axi_rready && s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				n = 99;
			end else if (s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_rready <= 1'b1;
			end
		end
		if (n != 99) mismatches++;
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(what, e, d);
	endtask
	// Long enough for two sync stages, a full quarter cycle and the output registers
	task automatic settle;
		repeat (12) @(posedge aclk);
	endtask
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		rchk("config", cfg, 32'h0);
		rchk("link", lnk, 32'h2);
		s_axi_wstrb <= 4'h0;
		wr(cfg, 32'h6);
		s_axi_wstrb <= 4'hf;
		rchk("no strobe", cfg, 32'h0);
		rd(8'h14, d, r);
		chk("unmapped", cmp_pkg::resp_slverr, r);
		wr(8'h14, 32'h0);
		chk("unmapped write", cmp_pkg::resp_slverr, last_bresp);
		wr(lnk, 32'h2);
		chk("mapped write", cmp_pkg::resp_okay, last_bresp);
		$display("reset test done");
	endtask
	task automatic t_modes;
		logic [2:0] m;
		for (int i = 0; i < 8; i++) begin
			m = 3'(i);
			wr(cfg, {28'h0, 1'b1, m});
			repeat (2) @(posedge aclk);
			chk("pin enable", m == 3'h6, pin_out_enable);
			chk("analog", m == 3'h7 ? 4'h0 : 4'hf, input_analog);
			chk("switch", m == 3'h1 || m == 3'h2, input_switch_sel);
			chk("a on", m != 3'h0 && m != 3'h7, cmp_a_enable);
			chk("b on", m != 3'h0 && m != 3'h5 && m != 3'h7, cmp_b_enable);
		end
		$display("mode test done");
	endtask
	task automatic t_invert;
		logic [1:0] v;
		cmp_a_raw <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			v = 2'(i);
			wr(cfg, {26'h0, v, 4'h4});
			settle;
			chk("a out", !v[0], cmp_a_pin_out);
			chk("b out", v[1], cmp_b_pin_out);
			rchk("state", cfg, {24'h0, v[1], !v[0], v, 4'h4});
		end
		wr(cfg, 32'h30);
		settle;
		chk("off out", 2'b00, {cmp_b_pin_out, cmp_a_pin_out});
		$display("invert test done");
	endtask
	task automatic t_event;
		wr(cfg, 32'h4);
		sleeping <= 1'b1;
		settle;
		rchk("reference", cfg, 32'h44);
		wr(flg, 32'h0);
		wr(cmp_pkg::addr_enables, 32'h7);
		cmp_a_raw <= 1'b0;
		settle;
		chk("irq", 1'b1, irq_request);
		chk("wake", 1'b1, wake_request);
		rchk("change", flg, 32'h3);
		wr(flg, 32'h0);
		rchk("held", flg, 32'h3);
		cmp_a_raw <= 1'b1;
		settle;
		rchk("returned", flg, 32'h1);
		cmp_a_raw <= 1'b0;
		settle;
		wr(cfg, 32'h4);
		rchk("write ends", flg, 32'h1);
		wr(flg, 32'h0);
		rchk("cleared", flg, 32'h0);
		wr(cmp_pkg::addr_enables, 32'h3);
		wr(flg, 32'h1);
		repeat (2) @(posedge aclk);
		chk("masked", 1'b0, irq_request);
		chk("wake set", 1'b1, wake_request);
		sleeping <= 1'b0;
		$display("event test done");
	endtask
	task automatic t_gate;
		for (int i = 0; i < 2; i++) begin
			cmp_b_raw <= i[0];
			ext_gate_pin <= !i[0];
			wr(lnk, 32'h0);
			settle;
			chk("gate result", i[0], timer_gate);
			wr(lnk, 32'h2);
			settle;
			chk("gate pin", !i[0], timer_gate);
		end
		$display("gate test done");
	endtask
	// Result b reaches the gate only on a falling timer clock edge
	task automatic t_sync;
		cmp_b_raw <= 1'b1;
		wr(lnk, 32'h1);
		settle;
		chk("sync hold", 1'b0, timer_gate);
		timer_clk_prescaled <= 1'b1;
		settle;
		chk("sync rise", 1'b0, timer_gate);
		timer_clk_prescaled <= 1'b0;
		settle;
		chk("sync latch", 1'b1, timer_gate);
		wr(lnk, 32'h2);
		$display("sync test done");
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		forever #20 aclk = ~aclk;
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_modes;
		t_invert;
		t_event;
		t_gate;
		t_sync;
		results;
	end
	initial begin
		repeat (5000) @(posedge aclk);
		mismatches++;
		results;
	end
endmodule
